// file: hw/tmr0_flag.sv
// Sticky event flag with write-one clear and vector acknowledge
`timescale 1ns/1ps
`default_nettype none

module tmr0_flag (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic set_i,
   input  wire logic wclr_i,
   input  wire logic ack_i,
   output var  logic flag_o
);

   typedef struct packed {
      logic flag;
   } tmr0_flag_st_t;

   tmr0_flag_st_t st_r;
   tmr0_flag_st_t st_nxt;

   // Set beats either clear so a coincident event is not lost
   always_comb begin
      st_nxt = st_r;
      if (set_i) begin
         st_nxt.flag = 1'b1;
      end else if (wclr_i || ack_i) begin
         st_nxt.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag_o = st_r.flag;

endmodule : tmr0_flag

`default_nettype wire

// file: hw/tmr0_pkg.sv
// Shared constants and types of the 8-bit timer register interface
package tmr0_pkg;

   // Data-space offsets of the registers
   localparam logic [7:0] OFS_FLAGS  = 8'h35;
   localparam logic [7:0] OFS_SYNC   = 8'h43;
   localparam logic [7:0] OFS_COUNT  = 8'h46;
   localparam logic [7:0] OFS_CMPA   = 8'h47;
   localparam logic [7:0] OFS_CMPB   = 8'h48;
   localparam logic [7:0] OFS_IRQEN  = 8'h6e;

   // Short I/O space sits this far below the data space
   localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
   // Registers from here up answer to load and store only
   localparam logic [7:0] EXT_IO_BASE    = 8'h60;

   // Bit positions in enable and flag registers
   localparam int BIT_OVF  = 0;
   localparam int BIT_CMPA = 1;
   localparam int BIT_CMPB = 2;
   // Bit positions in the sync control register
   localparam int BIT_SHARED_RST = 0;
   localparam int BIT_ASYNC_RST  = 1;
   localparam int BIT_SYNC_HOLD  = 7;

   // Values after reset
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_BITS = 3'h0;

   // Counter limits
   localparam logic [7:0] CNT_MAX    = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;

   // Prescaler taps: a tick when the low bits are all ones
   localparam int PRESC_W = 10;
   localparam logic [9:0] TAP_DIV8    = 10'h007;
   localparam logic [9:0] TAP_DIV64   = 10'h03f;
   localparam logic [9:0] TAP_DIV256  = 10'h0ff;
   localparam logic [9:0] TAP_DIV1024 = 10'h3ff;

   // Waveform mode select encodings
   typedef enum logic [2:0] {
      WM_NORMAL   = 3'b000,
      WM_PC_MAX   = 3'b001,
      WM_CTC      = 3'b010,
      WM_FAST_MAX = 3'b011,
      WM_RSVD4    = 3'b100,
      WM_PC_CMPA  = 3'b101,
      WM_RSVD6    = 3'b110,
      WM_FAST_CMPA = 3'b111
   } tmr0_wmode_t;

   // Clock select encodings
   typedef enum logic [2:0] {
      CS_STOP    = 3'b000,
      CS_DIV1    = 3'b001,
      CS_DIV8    = 3'b010,
      CS_DIV64   = 3'b011,
      CS_DIV256  = 3'b100,
      CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } tmr0_csel_t;

   // Counting direction, used by the phase correct modes
   typedef enum logic {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } tmr0_dir_t;

   // One processor access, address is data space or I/O space
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmr0_bus_req_t;

   // Per-source triple: overflow, compare A, compare B
   typedef struct packed {
      logic cmp_b;
      logic cmp_a;
      logic ovf;
   } tmr0_src_t;

endpackage : tmr0_pkg

// file: hw/tmr0_presc.sv
// Shared prescaler and timer clock selection
`timescale 1ns/1ps
`default_nettype none

module tmr0_presc (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   input  wire logic                presc_rst_i,
   input  wire tmr0_pkg::tmr0_csel_t csel_i,
   input  wire logic                ext_pin_i,
   output var  logic                tick_o
);

   typedef struct packed {
      logic [tmr0_pkg::PRESC_W-1:0] div;
      logic                         pin_prev;
   } tmr0_presc_st_t;

   tmr0_presc_st_t st_r;
   tmr0_presc_st_t st_nxt;
   logic [tmr0_pkg::PRESC_W-1:0] tap;

   // Divider freezes at zero while held, so all users restart aligned
   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_prev = ext_pin_i;
      if (presc_rst_i) begin
         st_nxt.div = '0;
      end else begin
         st_nxt.div = st_r.div + 1'b1;
      end
   end

   // Tick selection; external edges are not gated by the prescaler
   always_comb begin
      tap    = '0;
      tick_o = 1'b0;
      case (csel_i)
         tmr0_pkg::CS_DIV1:     tap = '0;
         tmr0_pkg::CS_DIV8:     tap = tmr0_pkg::TAP_DIV8;
         tmr0_pkg::CS_DIV64:    tap = tmr0_pkg::TAP_DIV64;
         tmr0_pkg::CS_DIV256:   tap = tmr0_pkg::TAP_DIV256;
         tmr0_pkg::CS_DIV1024:  tap = tmr0_pkg::TAP_DIV1024;
         default:               tap = '0;
      endcase
      case (csel_i)
         tmr0_pkg::CS_STOP: begin
            tick_o = 1'b0;
         end
         tmr0_pkg::CS_EXT_FALL: begin
            tick_o = st_r.pin_prev && !ext_pin_i;
         end
         tmr0_pkg::CS_EXT_RISE: begin
            tick_o = !st_r.pin_prev && ext_pin_i;
         end
         default: begin
            tick_o = !presc_rst_i && ((st_r.div & tap) == tap);
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : tmr0_presc

`default_nettype wire

// file: hw/tmr0_regif.sv
// 8-bit timer 0 with its processor-visible register interface
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Enable register at 0x6E, reset zero, bits 2..0 compare B, A, overflow.
// - Compare B request needs global enable, its enable bit and its flag.
// - Compare A request needs global enable, its enable bit and its flag.
// - Overflow request needs global enable, its enable bit and its flag.
// - Flag register at 0x35, I/O 0x15, reset zero, bits B, A, overflow.
// - Counter equal to a compare register sets that compare flag.
// - Entering the handler vector clears the matching flag.
// - Writing one clears a flag, writing zero leaves it.
// - Overflow flag sets on overflow, point chosen by waveform mode.
// - Sync control at 0x43, I/O 0x23: hold mode, async and shared reset.
// - In hold mode both prescaler reset bits keep their written values.
// - Writing hold mode zero while in hold mode clears both prescaler reset bits.
// - Async reset bit resets timer 2 prescaler, self-clears unless held.
// - In async mode that bit stays set until the reset completes.
// - Shared reset bit resets the timer 0/1 prescaler, self-clears.
// - Counter register at 0x46, I/O 0x26, reset zero, read and write.
// - A counter write blocks compare match on the next timer tick.
// - Compare A at 0x47, I/O 0x27, drives flag A and wave output A.
// - Compare B at 0x48, I/O 0x28, drives flag B and wave output B.
module tmr0_regif (
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_n_i,
   input  wire tmr0_pkg::tmr0_bus_req_t bus_req_i,
   output var  logic [7:0]              bus_rdata_o,
   input  wire logic                    global_irq_enable_i,
   input  wire tmr0_pkg::tmr0_src_t     irq_ack_i,
   output var  tmr0_pkg::tmr0_src_t     irq_req_o,
   input  wire tmr0_pkg::tmr0_wmode_t   waveform_mode_select_i,
   input  wire tmr0_pkg::tmr0_csel_t    clk_select_i,
   input  wire logic                    ext_clk_pin_i,
   input  wire logic                    async_mode_i,
   input  wire logic                    async_presc_done_i,
   output var  logic                    async_prescaler_reset_o,
   output var  logic                    wave_out_a_o,
   output var  logic                    wave_out_b_o
);

   // Whole state of the block apart from the three flag cells and the prescaler
   typedef struct packed {
      logic [7:0]          count;
      logic [7:0]          cmp_a;
      logic [7:0]          cmp_b;
      logic [2:0]          irq_en;
      logic                sync_hold;
      logic                async_rst;
      logic                shared_rst;
      tmr0_pkg::tmr0_dir_t dir;
      logic                blocked;
      logic [7:0]          rdata;
      tmr0_pkg::tmr0_src_t irq;
      logic                wave_a;
      logic                wave_b;
   } tmr0_st_t;

   tmr0_st_t st_r;
   tmr0_st_t st_nxt;

   logic [7:0]          eff_addr;
   logic                addr_ok;
   logic                wr_flags;
   logic                wr_sync;
   logic                wr_count;
   logic                wr_cmpa;
   logic                wr_cmpb;
   logic                wr_irqen;
   logic                tick;
   logic [7:0]          top;
   logic                phase_correct;
   logic                ovf_evt;
   logic                match_a;
   logic                match_b;
   tmr0_pkg::tmr0_src_t flags;
   tmr0_pkg::tmr0_src_t flag_set;
   tmr0_pkg::tmr0_src_t flag_wclr;

   // Map an I/O space access onto the data space; I/O reach stops at 0x5f
   always_comb begin
      if (bus_req_i.io_space) begin
         eff_addr = 8'(bus_req_i.addr + tmr0_pkg::IO_SPACE_SHIFT);
         addr_ok  = (eff_addr < tmr0_pkg::EXT_IO_BASE);
      end else begin
         eff_addr = bus_req_i.addr;
         addr_ok  = 1'b1;
      end
   end

   // Write decode
   always_comb begin
      wr_flags = 1'b0;
      wr_sync  = 1'b0;
      wr_count = 1'b0;
      wr_cmpa  = 1'b0;
      wr_cmpb  = 1'b0;
      wr_irqen = 1'b0;
      if (!bus_req_i.wr || !addr_ok) begin
         wr_flags = 1'b0;
      end else if (eff_addr == tmr0_pkg::OFS_FLAGS) begin
         wr_flags = 1'b1;
      end else if (eff_addr == tmr0_pkg::OFS_SYNC) begin
         wr_sync = 1'b1;
      end else if (eff_addr == tmr0_pkg::OFS_COUNT) begin
         wr_count = 1'b1;
      end else if (eff_addr == tmr0_pkg::OFS_CMPA) begin
         wr_cmpa = 1'b1;
      end else if (eff_addr == tmr0_pkg::OFS_CMPB) begin
         wr_cmpb = 1'b1;
      end else if (eff_addr == tmr0_pkg::OFS_IRQEN) begin
         wr_irqen = 1'b1;
      end
   end

   // Shared prescaler; a held reset also stops the undivided clock
   tmr0_presc u_presc (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .presc_rst_i (st_r.shared_rst),
      .csel_i      (clk_select_i),
      .ext_pin_i   (ext_clk_pin_i),
      .tick_o      (tick)
   );

   // Top value and overflow point follow the waveform mode
   always_comb begin
      phase_correct = (waveform_mode_select_i == tmr0_pkg::WM_PC_MAX) ||
                      (waveform_mode_select_i == tmr0_pkg::WM_PC_CMPA);
      case (waveform_mode_select_i)
         tmr0_pkg::WM_CTC,
         tmr0_pkg::WM_PC_CMPA,
         tmr0_pkg::WM_FAST_CMPA: top = st_r.cmp_a;
         default:                top = tmr0_pkg::CNT_MAX;
      endcase
      if (phase_correct) begin
         ovf_evt = tick && (st_r.dir == tmr0_pkg::DIR_DOWN) &&
                   (st_r.count == tmr0_pkg::CNT_BOTTOM);
      end else if (waveform_mode_select_i == tmr0_pkg::WM_FAST_CMPA) begin
         ovf_evt = tick && (st_r.count == top);
      end else begin
         ovf_evt = tick && (st_r.count == tmr0_pkg::CNT_MAX);
      end
   end

   // Compare units; the first tick after a counter write never matches
   assign match_a = tick && !st_r.blocked &&
                    (st_r.count == st_r.cmp_a);
   assign match_b = tick && !st_r.blocked &&
                    (st_r.count == st_r.cmp_b);

   // Flag cell inputs: hardware set, write-one clear, vector entry
   always_comb begin
      flag_set.ovf    = ovf_evt;
      flag_set.cmp_a  = match_a;
      flag_set.cmp_b  = match_b;
      flag_wclr.ovf   = wr_flags && bus_req_i.wdata[tmr0_pkg::BIT_OVF];
      flag_wclr.cmp_a = wr_flags && bus_req_i.wdata[tmr0_pkg::BIT_CMPA];
      flag_wclr.cmp_b = wr_flags && bus_req_i.wdata[tmr0_pkg::BIT_CMPB];
   end

   tmr0_flag u_flag_ovf (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .set_i     (flag_set.ovf),
      .wclr_i    (flag_wclr.ovf),
      .ack_i     (irq_ack_i.ovf),
      .flag_o    (flags.ovf)
   );

   tmr0_flag u_flag_cmpa (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .set_i     (flag_set.cmp_a),
      .wclr_i    (flag_wclr.cmp_a),
      .ack_i     (irq_ack_i.cmp_a),
      .flag_o    (flags.cmp_a)
   );

   tmr0_flag u_flag_cmpb (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .set_i     (flag_set.cmp_b),
      .wclr_i    (flag_wclr.cmp_b),
      .ack_i     (irq_ack_i.cmp_b),
      .flag_o    (flags.cmp_b)
   );

   // Next state: registers, counter, sync control, requests, read data
   always_comb begin
      st_nxt = st_r;
      // Plain read/write registers
      if (wr_cmpa) begin
         st_nxt.cmp_a = bus_req_i.wdata;
      end
      if (wr_cmpb) begin
         st_nxt.cmp_b = bus_req_i.wdata;
      end
      if (wr_irqen) begin
         st_nxt.irq_en = bus_req_i.wdata[2:0];
      end
      // Counter: a software write beats the count step
      if (wr_count) begin
         st_nxt.count   = bus_req_i.wdata;
         st_nxt.blocked = 1'b1;
      end else if (tick) begin
         st_nxt.blocked = 1'b0;
         if (phase_correct) begin
            if (st_r.dir == tmr0_pkg::DIR_UP) begin
               if (st_r.count == top) begin
                  st_nxt.dir   = tmr0_pkg::DIR_DOWN;
                  st_nxt.count = st_r.count - 8'h01;
               end else begin
                  st_nxt.count = st_r.count + 8'h01;
               end
            end else if (st_r.count == tmr0_pkg::CNT_BOTTOM) begin
               st_nxt.dir   = tmr0_pkg::DIR_UP;
               st_nxt.count = st_r.count + 8'h01;
            end else begin
               st_nxt.count = st_r.count - 8'h01;
            end
         end else begin
            st_nxt.dir = tmr0_pkg::DIR_UP;
            if (st_r.count == top) begin
               st_nxt.count = tmr0_pkg::CNT_BOTTOM;
            end else begin
               st_nxt.count = st_r.count + 8'h01;
            end
         end
      end
      // Prescaler resets self-clear unless hold mode, or for the async bit an unfinished async reset, keeps them
      if (!st_r.sync_hold) begin
         st_nxt.shared_rst = 1'b0;
         if (!(async_mode_i && !async_presc_done_i)) begin
            st_nxt.async_rst = 1'b0;
         end
      end
      if (wr_sync) begin
         st_nxt.sync_hold  = bus_req_i.wdata[tmr0_pkg::BIT_SYNC_HOLD];
         st_nxt.shared_rst = bus_req_i.wdata[tmr0_pkg::BIT_SHARED_RST] |
                             (st_r.sync_hold & st_r.shared_rst);
         st_nxt.async_rst  = bus_req_i.wdata[tmr0_pkg::BIT_ASYNC_RST] |
                             (st_r.async_rst & st_nxt.async_rst);
         // Leaving hold mode releases all timers in the same cycle
         if (st_r.sync_hold && !bus_req_i.wdata[tmr0_pkg::BIT_SYNC_HOLD])
         begin
            st_nxt.shared_rst = 1'b0;
            st_nxt.async_rst  = 1'b0;
         end
      end
      // Requests follow flag, enable and global enable level-wise
      st_nxt.irq.cmp_b = global_irq_enable_i &&
                         st_r.irq_en[tmr0_pkg::BIT_CMPB] &&
                         flags.cmp_b;
      st_nxt.irq.cmp_a = global_irq_enable_i &&
                         st_r.irq_en[tmr0_pkg::BIT_CMPA] &&
                         flags.cmp_a;
      st_nxt.irq.ovf   = global_irq_enable_i &&
                         st_r.irq_en[tmr0_pkg::BIT_OVF] &&
                         flags.ovf;
      // Match events to the waveform generator, one cycle each
      st_nxt.wave_a = match_a;
      st_nxt.wave_b = match_b;
      // Read data is registered; unmapped reads return zero
      st_nxt.rdata = tmr0_pkg::RST_BYTE;
      if (!bus_req_i.rd || !addr_ok) begin
         st_nxt.rdata = tmr0_pkg::RST_BYTE;
      end else if (eff_addr == tmr0_pkg::OFS_FLAGS) begin
         st_nxt.rdata = {5'h00, flags};
      end else if (eff_addr == tmr0_pkg::OFS_SYNC) begin
         st_nxt.rdata = {st_r.sync_hold, 5'h00,
                         st_r.async_rst, st_r.shared_rst};
      end else if (eff_addr == tmr0_pkg::OFS_COUNT) begin
         st_nxt.rdata = st_r.count;
      end else if (eff_addr == tmr0_pkg::OFS_CMPA) begin
         st_nxt.rdata = st_r.cmp_a;
      end else if (eff_addr == tmr0_pkg::OFS_CMPB) begin
         st_nxt.rdata = st_r.cmp_b;
      end else if (eff_addr == tmr0_pkg::OFS_IRQEN) begin
         st_nxt.rdata = {5'h00, st_r.irq_en};
      end
   end

   // State register, every field cleared by reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign bus_rdata_o             = st_r.rdata;
   assign irq_req_o               = st_r.irq;
   assign async_prescaler_reset_o = st_r.async_rst;
   assign wave_out_a_o            = st_r.wave_a;
   assign wave_out_b_o            = st_r.wave_b;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   // Checks kept beside the logic they guard
   property p_enable_write;
      wr_irqen |=> st_r.irq_en == $past(bus_req_i.wdata[2:0]);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable register did not take the write");
   property p_req_b;
      (global_irq_enable_i && st_r.irq_en[2] && flags.cmp_b)
         |=> irq_req_o.cmp_b;
   endproperty
   a_req_b: assert property (p_req_b)
      else $error("compare B request missing");
   property p_req_a;
      irq_req_o.cmp_a |-> $past(global_irq_enable_i && st_r.irq_en[1] &&
                                flags.cmp_a);
   endproperty
   a_req_a: assert property (p_req_a)
      else $error("compare A request without cause");
   property p_req_ovf;
      !global_irq_enable_i |=> !irq_req_o.ovf;
   endproperty
   a_req_ovf: assert property (p_req_ovf)
      else $error("overflow request while globally disabled");
   property p_match_a;
      (tick && !st_r.blocked && st_r.count == st_r.cmp_a) |=> flags.cmp_a;
   endproperty
   a_match_a: assert property (p_match_a)
      else $error("compare A match did not set its flag");
   property p_wclr;
      (wr_flags && bus_req_i.wdata[0] && !ovf_evt) |=> !flags.ovf;
   endproperty
   a_wclr: assert property (p_wclr)
      else $error("write one did not clear overflow flag");
   property p_hold_keeps;
      (st_r.sync_hold && !wr_sync) |=> $stable(st_r.shared_rst) &&
                                       $stable(st_r.async_rst);
   endproperty
   a_hold_keeps: assert property (p_hold_keeps)
      else $error("reset bits changed in hold mode");
   property p_hold_leave;
      (wr_sync && st_r.sync_hold && !bus_req_i.wdata[7])
         |=> !st_r.shared_rst && !st_r.async_rst;
   endproperty
   a_hold_leave: assert property (p_hold_leave)
      else $error("leaving hold mode did not clear reset bits");
   property p_shared_self;
      (st_r.shared_rst && !st_r.sync_hold && !wr_sync) |=> !st_r.shared_rst;
   endproperty
   a_shared_self: assert property (p_shared_self)
      else $error("shared prescaler reset did not self-clear");
   property p_block;
      wr_count |=> st_r.blocked && st_r.count == $past(bus_req_i.wdata)
                   ##0 (!match_a && !match_b) [*1];
   endproperty
   a_block: assert property (p_block)
      else $error("counter write not taken or match not blocked");

endmodule : tmr0_regif

`default_nettype wire

// file: tb/test_tmr0_regif.sv
// Register level testbench of the timer register interface
`timescale 1ns/1ps
`default_nettype none

module test_tmr0_regif;
   logic                    clk_sys_i = 1'b0;
   logic                    rst_n_i   = 1'b0;
   tmr0_pkg::tmr0_bus_req_t req       = '0;
   logic [7:0]              rdata;
   logic                    gie       = 1'b0;
   logic                    serve     = 1'b0;
   tmr0_pkg::tmr0_src_t     ack;
   tmr0_pkg::tmr0_src_t     irq;
   tmr0_pkg::tmr0_csel_t    cs        = tmr0_pkg::CS_STOP;
   logic                    amode     = 1'b0;
   logic                    adone     = 1'b0;
   logic                    apr;
   logic                    wa;
   logic                    wb;
   tmr0_pkg::tmr0_wmode_t   wm        = tmr0_pkg::WM_NORMAL;
   int                      wa_n      = 0;
   int                      wb_n      = 0;
   int                      fails     = 0;
   int                      cmp_count = 0;
   int                      cyc       = 0;
   logic [7:0]              ofs [6]   = '{8'h35, 8'h43, 8'h46, 8'h47,
                                          8'h48, 8'h6e};

   always #25 clk_sys_i = ~clk_sys_i;

   tmr0_regif uut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(req),
      .bus_rdata_o(rdata), .global_irq_enable_i(gie),
      .irq_ack_i(ack), .irq_req_o(irq),
      .waveform_mode_select_i(wm),
      .clk_select_i(cs), .ext_clk_pin_i(1'b0), .async_mode_i(amode),
      .async_presc_done_i(adone), .async_prescaler_reset_o(apr),
      .wave_out_a_o(wa), .wave_out_b_o(wb));

   tmr0_cpu_model cpu (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .serve_i(serve),
      .irq_req_i(irq), .irq_ack_o(ack));

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // One bus access; a read compares data one cycle after its edge
   task automatic acc(input logic r, input logic io, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] e);
      @(posedge clk_sys_i);
      req <= '{rd: r, wr: !r, io_space: io, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req <= '0;
      if (r) begin
         #1;
         chk("read data", e, rdata);
      end
   endtask : acc

   task automatic run(input tmr0_pkg::tmr0_csel_t c, input int n);
      cs <= c;
      repeat (n) @(posedge clk_sys_i);
      cs <= tmr0_pkg::CS_STOP;
   endtask : run

   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // Hang guard, generous against roughly 220 cycles of tests
   // Also counts match pulses, which last too short for a later compare
   always @(posedge clk_sys_i) begin
      cyc++;
      if (wa) begin
         wa_n++;
      end
      if (wb) begin
         wb_n++;
      end
      if (cyc == 3000) begin
         fails++;
         results();
      end
   end

   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 6; i++) acc(1, 0, ofs[i], 8'h00, 8'h00);
      acc(0, 0, 8'h6e, 8'hff, 0);
      acc(1, 0, 8'h6e, 0, 8'h07);
      acc(0, 1, 8'h27, 8'h20, 0);
      acc(1, 0, 8'h47, 0, 8'h20);
      acc(0, 0, 8'h48, 8'h30, 0);
      acc(1, 1, 8'h28, 0, 8'h30);
      acc(0, 0, 8'h46, 8'h10, 0);
      acc(1, 1, 8'h26, 0, 8'h10);
      acc(1, 1, 8'h4e, 0, 8'h00);
      // Count through both compare values, then stop to look
      run(tmr0_pkg::CS_DIV1, 40);
      acc(1, 1, 8'h15, 0, 8'h06);
      chk("wave a pulses", 8'h01, wa_n[7:0]);
      chk("wave b pulses", 8'h01, wb_n[7:0]);
      chk("request", 8'h00, {5'h0, irq});
      gie <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk("request", 8'h06, {5'h0, irq});
      serve <= 1'b1;
      repeat (12) @(posedge clk_sys_i);
      serve <= 1'b0;
      acc(1, 0, 8'h35, 0, 8'h00);
      acc(0, 0, 8'h46, 8'hf0, 0);
      run(tmr0_pkg::CS_DIV1, 20);
      acc(1, 0, 8'h35, 0, 8'h01);
      chk("request", 8'h01, {5'h0, irq});
      acc(0, 0, 8'h35, 8'h06, 0);
      acc(1, 0, 8'h35, 0, 8'h01);
      acc(0, 1, 8'h15, 8'h01, 0);
      acc(1, 0, 8'h35, 0, 8'h00);
      // Counter write onto compare A while running
      cs <= tmr0_pkg::CS_DIV1;
      acc(0, 0, 8'h46, 8'h20, 0);
      run(tmr0_pkg::CS_DIV1, 4);
      acc(1, 0, 8'h35, 0, 8'h00);
      // Hold mode keeps the shared prescaler in reset
      acc(0, 0, 8'h46, 8'h50, 0);
      acc(0, 1, 8'h23, 8'h81, 0);
      run(tmr0_pkg::CS_DIV1, 10);
      acc(1, 0, 8'h43, 0, 8'h81);
      acc(1, 0, 8'h46, 0, 8'h50);
      acc(0, 0, 8'h43, 8'h00, 0);
      acc(1, 0, 8'h43, 0, 8'h00);
      acc(0, 0, 8'h43, 8'h01, 0);
      repeat (2) @(posedge clk_sys_i);
      acc(1, 0, 8'h43, 0, 8'h00);
      amode <= 1'b1;
      acc(0, 0, 8'h43, 8'h02, 0);
      repeat (3) @(posedge clk_sys_i);
      acc(1, 0, 8'h43, 0, 8'h02);
      chk("async reset", 8'h01, {7'h0, apr});
      adone <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      acc(1, 0, 8'h43, 0, 8'h00);
      // Phase correct up to compare A, back down, overflow at bottom:
      // 0x1e up to 0x20 takes 3 ticks, down to zero 31, the 35th overflows
      wm <= tmr0_pkg::WM_PC_CMPA;
      acc(0, 0, 8'h46, 8'h1e, 0);
      run(tmr0_pkg::CS_DIV1, 35);
      acc(1, 0, 8'h35, 0, 8'h03);
      acc(1, 0, 8'h46, 0, 8'h01);
      chk("wave a pulses", 8'h02, wa_n[7:0]);
      chk("wave b pulses", 8'h01, wb_n[7:0]);
      results();
   end
endmodule : test_tmr0_regif

`default_nettype wire

// file: tb/tmr0_cpu_model.sv
// Processor interrupt logic model that enters one handler at a time
`timescale 1ns/1ps
`default_nettype none

module tmr0_cpu_model (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   input  wire logic                serve_i,
   input  wire tmr0_pkg::tmr0_src_t irq_req_i,
   output var  tmr0_pkg::tmr0_src_t irq_ack_o
);
   logic [1:0] busy_r;
   logic [2:0] req;
   assign req = irq_req_i;

   // Vector entry pulse; waits out the request fall before the next one
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_r    <= 2'h0;
         irq_ack_o <= '0;
      end else begin
         irq_ack_o <= '0;
         if (busy_r != 2'h0) begin
            busy_r <= busy_r - 2'h1;
         end else if (serve_i && req != 3'h0) begin
            irq_ack_o <= req & (~req + 3'h1);
            busy_r    <= 2'h3;
         end
      end
   end
endmodule : tmr0_cpu_model

`default_nettype wire
